// ===== core/pe_gpio.sv
// Purpose: port e gpio with parallel slave control over apb
// Assumes: pins synchronous to sys_clk, psp strobes active low
// Notes: psp data bus itself lives on the companion port
//
// Contract
// RQ1: direction bit 1 input, 0 drives latch
// RQ2: analog pins read as zero
// RQ3: direction still gates drivers in analog mode
// RQ4: pins come up analog after reset
// RQ5: latch register reads back latch value
// RQ6: pin3 is input only when clear disabled
// RQ7: pin3 is reset input when clear enabled
// RQ8: bit7 flags unread received word
// RQ9: bit6 flags output word not yet read
// RQ10: bit5 sets on overrun, software clears
// RQ11: bit4 selects parallel slave mode
// RQ12: bit3 always reads zero
// RQ13: psp mode pins are read, write, select
// RQ14: output path ignores analog select
// RQ15: small variant has only pin3
// RQ16: analog select disables digital input buffer
// RQ17: analog bits 5..7 map to pins 0..2
// RQ18: data read gives pins, write sets latch
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module pe_gpio #(
  parameter bit FULL_PORT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic masterClearEnableConfig,
  input wire logic [2:0] pinIn,
  input wire logic pin3In,
  output logic [2:0] pinOut,
  output logic [2:0] pinOe,
  output logic externalResetReq,
  input wire logic [7:0] pspBusIn,
  output logic [7:0] pspBusOut,
  output logic pspBusOe
);
  // ****************************************************
  // bus decode
  // ****************************************************
  logic acc;
  logic wr;
  logic rd;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      pe_pkg::PE_OFF_DATA, pe_pkg::PE_OFF_LATCH, pe_pkg::PE_OFF_DIR,
      pe_pkg::PE_OFF_ANSEL, pe_pkg::PE_OFF_PSP_IN,
      pe_pkg::PE_OFF_PSP_OUT: pslverr = 1'b0;
      default: pslverr = acc;
    endcase
  end

  // ****************************************************
  // control registers
  // ****************************************************
  logic [2:0] lat_r, lat_nxt;
  logic [2:0] dir_r, dir_nxt;
  logic [2:0] ans_r, ans_nxt;
  logic mode_r, mode_nxt;
  logic ibf_r, ibf_nxt;
  logic obf_r, obf_nxt;
  logic input_overflow_flag_r, input_overflow_flag_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] strobe_r, strobe_nxt;
  logic [7:0] inWord;
  logic [7:0] outWord;
  logic pspActive;
  logic extWrEnd;
  logic extRdEnd;
  logic cpuRdIn;
  logic cpuWrOut;
  logic [2:0] dataIn;
  logic pin3Val;

  // strobes: pin0 read, pin1 write, pin2 select, active low
  assign pspActive = mode_r && (&dir_r) && FULL_PORT; // [RQ13]
  always_comb begin
    strobe_nxt[0] = pspActive && !pinIn[2] && !pinIn[0];
    strobe_nxt[1] = pspActive && !pinIn[2] && !pinIn[1];
  end
  assign extRdEnd = strobe_r[0] && !strobe_nxt[0];
  assign extWrEnd = strobe_r[1] && !strobe_nxt[1];
  assign cpuRdIn = rd && paddr == pe_pkg::PE_OFF_PSP_IN;
  assign cpuWrOut = wr && paddr == pe_pkg::PE_OFF_PSP_OUT;

  always_comb begin
    lat_nxt = lat_r;
    dir_nxt = dir_r;
    ans_nxt = ans_r;
    mode_nxt = mode_r;
    ibf_nxt = ibf_r;
    obf_nxt = obf_r;
    input_overflow_flag_nxt = input_overflow_flag_r;
    if (wr && FULL_PORT) begin
      if (paddr == pe_pkg::PE_OFF_DATA ||
          paddr == pe_pkg::PE_OFF_LATCH) begin
        lat_nxt = pwdata[2:0]; // [RQ5] [RQ18]
      end
      if (paddr == pe_pkg::PE_OFF_DIR) begin
        dir_nxt = pwdata[2:0]; // [RQ1]
        mode_nxt = pwdata[pe_pkg::PE_BIT_MODE]; // [RQ11]
        if (!pwdata[pe_pkg::PE_BIT_INPUT_OVERFLOW_FLAG]) begin
          input_overflow_flag_nxt = 1'b0; // [RQ10]
        end
      end
      if (paddr == pe_pkg::PE_OFF_ANSEL) begin
        ans_nxt = pwdata[pe_pkg::PE_ANS_LO +: 3]; // [RQ17]
      end
    end
    if (cpuRdIn) begin
      ibf_nxt = 1'b0; // [RQ8]
    end
    if (extRdEnd) begin
      obf_nxt = 1'b0; // [RQ9]
    end
    // cpu write sets, wins over host read
    if (cpuWrOut) begin
      obf_nxt = 1'b1; // [RQ9]
    end
    // set wins over clear
    if (extWrEnd) begin
      ibf_nxt = 1'b1; // [RQ8]
      if (ibf_r) begin
        input_overflow_flag_nxt = 1'b1; // [RQ10]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lat_r <= pe_pkg::PE_LAT_RST;
      dir_r <= pe_pkg::PE_DIR_RST;
      ans_r <= pe_pkg::PE_ANS_RST; // [RQ4]
      mode_r <= 1'b0;
      ibf_r <= 1'b0;
      obf_r <= 1'b0;
      input_overflow_flag_r <= 1'b0;
      rdata_r <= '0;
      strobe_r <= 2'h0;
    end else begin
      lat_r <= lat_nxt;
      dir_r <= dir_nxt;
      ans_r <= ans_nxt;
      mode_r <= mode_nxt;
      ibf_r <= ibf_nxt;
      obf_r <= obf_nxt;
      input_overflow_flag_r <= input_overflow_flag_nxt;
      rdata_r <= rdata_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  // ****************************************************
  // psp words
  // ****************************************************
  pe_word_reg #(.W(8)) u_in_word (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wrEn(extWrEnd),
    .wrData(pspBusIn),
    .rdData(inWord)
  );
  pe_word_reg #(.W(8)) u_out_word (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wrEn(cpuWrOut),
    .wrData(pwdata[7:0]),
    .rdData(outWord)
  );
  assign pspBusOut = outWord;
  assign pspBusOe = strobe_r[0];

  // ****************************************************
  // pins and read mux
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      // output path ignores analog select
      assign pinOut[g] = lat_r[g]; // [RQ14]
      assign pinOe[g] = FULL_PORT && !dir_r[g]; // [RQ1] [RQ3]
      assign dataIn[g] = FULL_PORT && !ans_r[g] && pinIn[g]; // [RQ2] [RQ16]
    end
  endgenerate
  assign pin3Val = !masterClearEnableConfig && pin3In; // [RQ6] [RQ15]
  assign externalResetReq = masterClearEnableConfig && !pin3In; // [RQ7]

  always_comb begin
    rdata_nxt = '0;
    case (paddr)
      pe_pkg::PE_OFF_DATA: rdata_nxt[3:0] = {pin3Val, dataIn}; // [RQ18]
      pe_pkg::PE_OFF_LATCH: rdata_nxt[2:0] = lat_r; // [RQ5]
      pe_pkg::PE_OFF_DIR: rdata_nxt[7:0] =
        {ibf_r, obf_r, input_overflow_flag_r, mode_r, 1'b0, dir_r}; // [RQ12]
      pe_pkg::PE_OFF_ANSEL: rdata_nxt[7:5] = ans_r;
      pe_pkg::PE_OFF_PSP_IN: rdata_nxt[7:0] = inWord;
      pe_pkg::PE_OFF_PSP_OUT: rdata_nxt[7:0] = outWord;
      default: rdata_nxt = '0;
    endcase
  end
  assign prdata = acc ? rdata_nxt : rdata_r;

  // ****************************************************
  // checks
  // ****************************************************
  property p_drive;
    @(posedge sys_clk) disable iff (!nrst)
      FULL_PORT |-> (pinOe == ~dir_r) && (pinOut == lat_r);
  endproperty
  a_drive: assert property (p_drive) // [RQ1]
    else $error("pin driver mismatch");
  property p_analog_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && paddr == pe_pkg::PE_OFF_DATA && ans_r[0]) |-> !prdata[0];
  endproperty
  a_analog_zero: assert property (p_analog_zero) // [RQ2]
    else $error("analog pin read nonzero");
  property p_reset_analog;
    @(posedge sys_clk) $rose(nrst) |-> ans_r == 3'h7;
  endproperty
  a_reset_analog: assert property (p_reset_analog) // [RQ4]
    else $error("pins not analog after reset");
  property p_latch_rd;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && FULL_PORT && paddr == pe_pkg::PE_OFF_LATCH) |=>
      lat_r == $past(pwdata[2:0]);
  endproperty
  a_latch_rd: assert property (p_latch_rd) // [RQ5]
    else $error("latch readback wrong");
  property p_ibf;
    @(posedge sys_clk) disable iff (!nrst)
      extWrEnd |=> ibf_r;
  endproperty
  a_ibf: assert property (p_ibf) // [RQ8]
    else $error("input full not set");
  property p_obf;
    @(posedge sys_clk) disable iff (!nrst)
      (extRdEnd && !cpuWrOut) |=> !obf_r;
  endproperty
  a_obf: assert property (p_obf) // [RQ9]
    else $error("output full not cleared");
  property p_input_overflow_flag;
    @(posedge sys_clk) disable iff (!nrst)
      (extWrEnd && ibf_r) |=> input_overflow_flag_r;
  endproperty
  a_input_overflow_flag: assert property (p_input_overflow_flag) // [RQ10]
    else $error("overflow not flagged");
  property p_bit3;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && paddr == pe_pkg::PE_OFF_DIR) |-> !prdata[3];
  endproperty
  a_bit3: assert property (p_bit3) // [RQ12]
    else $error("bit3 not zero");
  property p_external_reset_input;
    @(posedge sys_clk) disable iff (!nrst)
      masterClearEnableConfig |-> !pin3Val;
  endproperty
  a_external_reset_input: assert property (p_external_reset_input) // [RQ7]
    else $error("pin3 read while reset input");

  // ****************************************************
  // further checks
  // ****************************************************
  property p_oe_input;
    @(posedge sys_clk) disable iff (!nrst)
      (dir_r == 3'h7) |-> (pinOe == 3'h0);
  endproperty
  a_oe_input: assert property (p_oe_input) // [RQ3]
    else $error("input pin driven");
  property p_out_analog;
    @(posedge sys_clk) disable iff (!nrst)
      (ans_r != 3'h0) |-> (pinOut == lat_r);
  endproperty
  a_out_analog: assert property (p_out_analog) // [RQ14]
    else $error("output path affected by analog");
  property p_data_wr;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && FULL_PORT && paddr == pe_pkg::PE_OFF_DATA) |=>
      lat_r == $past(pwdata[2:0]);
  endproperty
  a_data_wr: assert property (p_data_wr) // [RQ18]
    else $error("data write missed latch");
  property p_pin3_in;
    @(posedge sys_clk) disable iff (!nrst)
      !masterClearEnableConfig |-> (pin3Val == pin3In);
  endproperty
  a_pin3_in: assert property (p_pin3_in) // [RQ6]
    else $error("pin3 input value wrong");
  property p_ext_rst;
    @(posedge sys_clk) disable iff (!nrst)
      (masterClearEnableConfig && !pin3In) |-> externalResetReq;
  endproperty
  a_ext_rst: assert property (p_ext_rst) // [RQ7]
    else $error("reset request missing");
  property p_ibf_clr;
    @(posedge sys_clk) disable iff (!nrst)
      (cpuRdIn && !extWrEnd) |=> !ibf_r;
  endproperty
  a_ibf_clr: assert property (p_ibf_clr) // [RQ8]
    else $error("input full not cleared");
  property p_obf_set;
    @(posedge sys_clk) disable iff (!nrst)
      cpuWrOut |=> obf_r;
  endproperty
  a_obf_set: assert property (p_obf_set) // [RQ9]
    else $error("output full not set");
  property p_input_overflow_flag_hold;
    @(posedge sys_clk) disable iff (!nrst)
      (input_overflow_flag_r && !(wr && paddr == pe_pkg::PE_OFF_DIR)) |=> input_overflow_flag_r;
  endproperty
  a_input_overflow_flag_hold: assert property (p_input_overflow_flag_hold) // [RQ10]
    else $error("overflow cleared by hardware");
  property p_mode_rd;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && paddr == pe_pkg::PE_OFF_DIR) |->
      prdata[pe_pkg::PE_BIT_MODE] == mode_r;
  endproperty
  a_mode_rd: assert property (p_mode_rd) // [RQ11]
    else $error("mode bit readback wrong");
  property p_dir_rd;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && paddr == pe_pkg::PE_OFF_DIR) |-> prdata[2:0] == dir_r;
  endproperty
  a_dir_rd: assert property (p_dir_rd) // [RQ1]
    else $error("direction readback wrong");
  property p_psp_gate;
    @(posedge sys_clk) disable iff (!nrst)
      !pspActive |=> (strobe_r == 2'h0);
  endproperty
  a_psp_gate: assert property (p_psp_gate) // [RQ13]
    else $error("strobe seen outside psp mode");
  property p_small;
    @(posedge sys_clk) disable iff (!nrst)
      !FULL_PORT |-> (pinOe == 3'h0);
  endproperty
  a_small: assert property (p_small) // [RQ15]
    else $error("small variant drives pins");
  property p_ans_pin2;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && paddr == pe_pkg::PE_OFF_DATA && ans_r[2]) |-> !prdata[2];
  endproperty
  a_ans_pin2: assert property (p_ans_pin2) // [RQ16]
    else $error("analog pin2 read nonzero");
  property p_ans_wr;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && FULL_PORT && paddr == pe_pkg::PE_OFF_ANSEL) |=>
      ans_r == $past(pwdata[pe_pkg::PE_ANS_LO +: 3]);
  endproperty
  a_ans_wr: assert property (p_ans_wr) // [RQ17]
    else $error("analog select write wrong");
endmodule : pe_gpio
`default_nettype wire

// ===== core/pe_pkg.sv
// Purpose: constants and types for the port e gpio block
// Assumes: apb slave, 32-bit data, one word per register
// Notes: offsets are byte addresses
`default_nettype none
package pe_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] PE_OFF_DATA = 8'h00;
  localparam logic [7:0] PE_OFF_LATCH = 8'h04;
  localparam logic [7:0] PE_OFF_DIR = 8'h08;
  localparam logic [7:0] PE_OFF_ANSEL = 8'h0c;
  localparam logic [7:0] PE_OFF_PSP_IN = 8'h10;
  localparam logic [7:0] PE_OFF_PSP_OUT = 8'h14;
  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int PE_BIT_IBF = 7;
  localparam int PE_BIT_OBF = 6;
  localparam int PE_BIT_INPUT_OVERFLOW_FLAG = 5;
  localparam int PE_BIT_MODE = 4;
  localparam int PE_ANS_LO = 5;
  localparam logic [2:0] PE_DIR_RST = 3'h7;
  localparam logic [2:0] PE_ANS_RST = 3'h7;
  localparam logic [2:0] PE_LAT_RST = 3'h0;
  localparam logic [7:0] PE_WORD_RST = 8'h00;

  typedef struct packed {
    logic [2:0] outVal;
    logic [2:0] outEn;
  } pe_pins_t;
endpackage : pe_pkg
`default_nettype wire

// ===== core/pe_word_reg.sv
// Purpose: one byte holding register with registered read data
// Assumes: single clock, async active-low reset
// Notes: used for the parallel slave input and output words
`default_nettype none
module pe_word_reg #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  output logic [W-1:0] rdData
);
  initial begin
    if (W < 1) $error("width must be positive");
  end
  logic [W-1:0] word_r;
  logic [W-1:0] word_nxt;
  always_comb begin
    word_nxt = wrEn ? wrData : word_r;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      word_r <= '0;
    end else begin
      word_r <= word_nxt;
    end
  end
  assign rdData = word_r;
endmodule : pe_word_reg
`default_nettype wire

// ===== verif/pe_gpio_bench.sv
// Purpose: self-checking bench of the port e block
// Assumes: zero-wait apb slave, pins looped through the pin model
// Notes: one task per scenario
`default_nettype none
module pe_gpio_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, extRst, pspOe, errSeen;
  logic mce = 1'b0;
  logic pin3In = 1'b1;
  logic [2:0] pinIn, pinOut, pinOe;
  logic [7:0] pspIn, pspOut;
  int errors = 0;
  int checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  pe_gpio pe_gpio_i (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .masterClearEnableConfig(mce), .pinIn(pinIn), .pin3In(pin3In),
    .pinOut(pinOut), .pinOe(pinOe), .externalResetReq(extRst),
    .pspBusIn(pspIn), .pspBusOut(pspOut), .pspBusOe(pspOe));
  pe_pin_model pe_pin_model_i (.sys_clk(sys_clk), .pinOut(pinOut),
    .pinOe(pinOe), .pinIn(pinIn), .pspBusIn(pspIn));
  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic finish_test;
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
    end
    r = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, {24'h0, exp});
  endtask : rd
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    chk({29'h0, pinOe}, 32'h0);
    rd(pe_pkg::PE_OFF_DIR, 8'h07);
    rd(pe_pkg::PE_OFF_ANSEL, 8'he0);
    rd(pe_pkg::PE_OFF_DATA, 8'h08);
  endtask : t_reset
  task automatic t_gpio;
    wr(pe_pkg::PE_OFF_DATA, 8'h05);
    rd(pe_pkg::PE_OFF_LATCH, 8'h05);
    chk({29'h0, pinOe}, 32'h0);
    wr(pe_pkg::PE_OFF_DIR, 8'h00);
    chk({26'h0, pinOe, pinOut}, 32'h3d);
    rd(pe_pkg::PE_OFF_DATA, 8'h08);
    wr(pe_pkg::PE_OFF_ANSEL, 8'h00);
    rd(pe_pkg::PE_OFF_DATA, 8'h0d);
    wr(pe_pkg::PE_OFF_ANSEL, 8'h20);
    rd(pe_pkg::PE_OFF_DATA, 8'h0c);
    wr(pe_pkg::PE_OFF_ANSEL, 8'h00);
    wr(pe_pkg::PE_OFF_DIR, 8'hcf);
    rd(pe_pkg::PE_OFF_DIR, 8'h07);
    pe_pin_model_i.extVal <= 3'h2;
    rd(pe_pkg::PE_OFF_DATA, 8'h0a);
    rd(pe_pkg::PE_OFF_LATCH, 8'h05);
    wr(pe_pkg::PE_OFF_LATCH, 8'h02);
    rd(pe_pkg::PE_OFF_LATCH, 8'h02);
    pe_pin_model_i.extVal <= 3'h7;
  endtask : t_gpio
  task automatic t_clear;
    mce <= 1'b1;
    pin3In <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, extRst}, 32'h1);
    mce <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, extRst}, 32'h0);
    rd(pe_pkg::PE_OFF_DATA, 8'h07);
    pin3In <= 1'b1;
  endtask : t_clear
  task automatic t_host;
    logic [31:0] r;
    wr(pe_pkg::PE_OFF_DIR, 8'h17);
    pe_pin_model_i.strobe(1, 8'ha5);
    rd(pe_pkg::PE_OFF_DIR, 8'h97);
    rd(pe_pkg::PE_OFF_PSP_IN, 8'ha5);
    rd(pe_pkg::PE_OFF_DIR, 8'h17);
    pe_pin_model_i.strobe(1, 8'h3c);
    pe_pin_model_i.strobe(1, 8'h66);
    rd(pe_pkg::PE_OFF_DIR, 8'hb7);
    apb(1'b0, pe_pkg::PE_OFF_PSP_IN, 32'h0, r);
    rd(pe_pkg::PE_OFF_DIR, 8'h37);
    wr(pe_pkg::PE_OFF_DIR, 8'h17);
    rd(pe_pkg::PE_OFF_DIR, 8'h17);
    wr(pe_pkg::PE_OFF_PSP_OUT, 8'h5a);
    rd(pe_pkg::PE_OFF_DIR, 8'h57);
    chk({24'h0, pspOut}, 32'h5a);
    pe_pin_model_i.extVal <= 3'h2;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pspOe}, 32'h1);
    pe_pin_model_i.extVal <= 3'h7;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pspOe}, 32'h0);
    rd(pe_pkg::PE_OFF_DIR, 8'h17);
  endtask : t_host
  task automatic t_unmapped;
    logic [31:0] r;
    apb(1'b0, 8'h18, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, errSeen}, 32'h1);
  endtask : t_unmapped
  // ****************************************************
  // main sequence and watchdog
  // ****************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_gpio();
    t_clear();
    t_host();
    t_unmapped();
    finish_test();
  end
  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule : pe_gpio_bench
`default_nettype wire

// ===== verif/pe_pin_model.sv
// Purpose: far side of the port pins, an external host on the strobes
// Assumes: host drives every pin that the port does not drive
// Notes: strobes are active low, select is pin2
`default_nettype none
module pe_pin_model (
  input wire logic sys_clk,
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  output logic [2:0] pinIn,
  output logic [7:0] pspBusIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] extVal = 3'h7;
  initial pspBusIn = 8'h00;
  // wire level from both parties
  assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
  // select plus one strobe low for two cycles
  task automatic strobe(input int idx, input logic [7:0] d);
    @(posedge sys_clk);
    extVal <= 3'h3 & ~3'(1 << idx);
    pspBusIn <= d;
    repeat (2) @(posedge sys_clk);
    extVal <= 3'h7;
    repeat (2) @(posedge sys_clk);
    pspBusIn <= ~d; // released bus shows no stale value
  endtask : strobe
endmodule : pe_pin_model
`default_nettype wire
